// ### dv/aso_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
module aso_ctl_model #(
  parameter int unsigned CAP_CYC = 30
) (
  input  wire logic   mclk,
  input  wire logic   rst_n,
  input  wire logic   sck_o,
  input  wire logic   sck_oe_n,
  input  wire logic   sck_pu_en,
  input  wire logic   sdo_o,
  input  wire logic   sdo_oe_n,
  input  wire logic   cs_pu_en,
  input  wire logic   cs_dis_en,
  input  wire logic   hold_low,
  output logic        sck_pin,
  output logic        sdo_pin,
  output logic        cs_below_thr,
  output logic [31:0] word,
  output int          nbits,
  output int          min_low
);
  int cap_q;
  int low_q;

  // ==========================================================
  // pins
  // hold_low only when a scenario pulls the clock pin low to pick external mode
  assign sck_pin = !sck_oe_n ? sck_o : hold_low ? 1'b0 : sck_pu_en ? 1'b1 : ~sck_o;
  // no pull on data: a released line must not look like the last bit
  assign sdo_pin = !sdo_oe_n ? sdo_o : ~sdo_o;
  assign cs_below_thr = (cap_q == 0);

  initial begin
    word = 32'h0;
    nbits = 0;
    min_low = 1000;
    low_q = 0;
    cap_q = CAP_CYC;
  end

  // ==========================================================
  // receiver, rising edges only
  always @(posedge sck_pin) begin
    if (rst_n === 1'b1) begin
      word <= {word[30:0], sdo_pin};
      nbits <= nbits + 1;
    end
  end

  // ==========================================================
  // low-phase width and timing capacitor
  always @(posedge mclk) begin
    if (sck_pin === 1'b0) begin
      low_q <= low_q + 1;
    end else begin
      if (low_q > 0 && low_q < min_low) min_low <= low_q;
      low_q <= 0;
    end
    if (!rst_n || cs_pu_en) cap_q <= CAP_CYC;
    else if (cs_dis_en && cap_q > 0) cap_q <= cap_q - 1;
  end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); \
  end \
end
module tb_top;
  import aso_pkg::*;
  localparam int POR = 40;
  localparam int H   = 4;
  localparam int SH  = 4;
  localparam int CAP = 30;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic              supply_ok = 1'b0;
  logic              cfg_autostart = 1'b0;
  logic              res_valid = 1'b0;
  logic              hold_low = 1'b0;
  logic [RES_W-1:0]  res_data = '0;
  logic              sck_o, sck_oe_n, sck_pu_en, sdo_o, sdo_oe_n, cs_pu_en, cs_dis_en;
  logic              conv_start, res_ready, samp_clk, mode_ext, sck_pin, sdo_pin, cs_below;
  logic [31:0]       word;
  int                nbits, min_low;
  int                n_errors = 0;
  int                comparisons = 0;

  initial begin
    forever #5 mclk = ~mclk;
  end

  aso_top #(.POR_CYCLES(POR), .SCK_HALF(H), .SAMP_HALF(SH), .DEPTH(8)) uut (
    .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .supply_ok(supply_ok),
    .cfg_autostart(cfg_autostart), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
    .sck_pu_en(sck_pu_en), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .cs_below_thr(cs_below),
    .cs_pu_en(cs_pu_en), .cs_dis_en(cs_dis_en), .conv_start(conv_start),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
    .samp_clk(samp_clk), .mode_ext(mode_ext));

  aso_ctl_model #(.CAP_CYC(CAP)) ctl (
    .mclk(mclk), .rst_n(rst_n), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .sck_pu_en(sck_pu_en),
    .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .cs_pu_en(cs_pu_en), .cs_dis_en(cs_dis_en),
    .hold_low(hold_low), .sck_pin(sck_pin), .sdo_pin(sdo_pin), .cs_below_thr(cs_below),
    .word(word), .nbits(nbits), .min_low(min_low));

  // ==========================================================
  // helpers
  task complete_run;
    $display("checks %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task expire(input string what);
    $display("Error timeout %s expected event seen none", what);
    n_errors++;
    complete_run();
  endtask

  task do_reset(input logic auto, input logic low);
    @(negedge mclk);
    rst_n = 1'b0;
    supply_ok = 1'b0;
    cfg_autostart = auto;
    hold_low = low;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    supply_ok = 1'b1;
  endtask

  // leaves res_valid up so back-to-back pushes need no gap
  task push(input logic [RES_W-1:0] d);
    int i;
    res_valid = 1'b1;
    res_data = d;
    for (i = 0; i < 1000 && res_ready !== 1'b1; i++) @(negedge mclk);
    @(negedge mclk);
  endtask

  task wait_bits(input int target);
    int i;
    for (i = 0; i < 3000 && nbits < target; i++) @(negedge mclk);
    if (nbits < target) expire("frame");
  endtask

  task wait_flag(input bit pu);
    int i;
    for (i = 0; i < 3000 && (pu ? cs_pu_en : cs_dis_en) !== 1'b1; i++) @(negedge mclk);
    if ((pu ? cs_pu_en : cs_dis_en) !== 1'b1) expire("chip select");
  endtask

  // ==========================================================
  // scenarios
  task t_ext;
    do_reset(1'b0, 1'b1);
    repeat (POR) @(negedge mclk);
    `CHK("mode_ext early", 1'b0, mode_ext);
    repeat (8) @(negedge mclk);
    `CHK("mode_ext", 1'b1, mode_ext);
    `CHK("sck_oe_n", 1'b1, sck_oe_n);
    `CHK("sdo_oe_n", 1'b1, sdo_oe_n);
    `CHK("sck_pu_en", 1'b0, sck_pu_en);
    $display("test ext done");
  endtask

  task t_cont;
    int i, k, n0;
    logic s;
    do_reset(1'b0, 1'b0);
    n0 = nbits;
    @(negedge mclk);
    // fill during reset phase, nothing drains yet
    for (i = 0; i < 8; i++) push(31'h5a3c_c3a5 + 31'(i) * 31'h0123_4567);
    `CHK("res_ready full", 1'b0, res_ready);
    res_valid = 1'b0;
    for (i = 0; i < 8; i++) begin
      wait_bits(n0 + 32 * (i + 1));
      `CHK("frame", ({1'b0, 31'h5a3c_c3a5 + 31'(i) * 31'h0123_4567}), word);
    end
    repeat (H) @(negedge mclk);
    `CHK("conv_start", 1'b1, conv_start);
    @(negedge mclk);
    `CHK("conv_start pulse", 1'b0, conv_start);
    repeat (2) @(negedge mclk);
    `CHK("sck idle", 1'b1, sck_pin);
    `CHK("sdo idle", 1'b1, sdo_pin);
    `CHK("sck driven", 1'b0, sck_oe_n);
    `CHK("sdo driven", 1'b0, sdo_oe_n);
    `CHK("cs pins", ({cs_pu_en, cs_dis_en}), 2'h0);
    `CHK("low phase", H, min_low);
    s = samp_clk;
    for (i = 0; i < 100 && samp_clk === s; i++) @(negedge mclk);
    s = samp_clk;
    for (k = 0; k < 100 && samp_clk === s; k++) @(negedge mclk);
    `CHK("samp half", SH, k);
    $display("test continuous done");
  endtask

  task t_auto;
    int n1;
    do_reset(1'b1, 1'b0);
    repeat (POR + 8) @(negedge mclk);
    `CHK("mode_ext", 1'b0, mode_ext);
    n1 = nbits;
    push(31'h7fff_ffff);
    res_valid = 1'b0;
    wait_flag(1'b0);
    `CHK("sleep sck_oe_n", 1'b1, sck_oe_n);
    `CHK("sleep pull-up", 1'b1, sck_pu_en);
    wait_flag(1'b1);
    `CHK("frame bits", n1 + 32, nbits);
    `CHK("frame", 32'h7fff_ffff, word);
    `CHK("discharge off", 1'b0, cs_dis_en);
    n1 = nbits;
    hold_low = 1'b1;
    // let the recharged capacitor clear the threshold sync before the next result
    repeat (4) @(negedge mclk);
    push(31'h0000_0001);
    res_valid = 1'b0;
    wait_flag(1'b0);
    repeat (4) @(negedge mclk);
    `CHK("pull-up off", 1'b0, sck_pu_en);
    repeat (CAP + 8) @(negedge mclk);
    `CHK("mode_ext", 1'b1, mode_ext);
    `CHK("no frame", n1, nbits);
    $display("test autostart done");
  endtask

  initial begin
    t_ext();
    t_cont();
    t_auto();
    complete_run();
  end
endmodule
`default_nettype wire

// ### hw/aso_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module aso_fifo
  import aso_pkg::*;
#(
  parameter int unsigned W     = RES_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] IDX_LAST = AW'(DEPTH - 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  function automatic logic [AW-1:0] idx_inc(input logic [AW-1:0] i);
    return (i == IDX_LAST) ? '0 : i + 1'b1;
  endfunction

  assign in_ready  = (cnt_q != CNT_FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ==========================================================
  // next state
  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = idx_inc(wr_q);
    end
    if (pop) begin
      rd_d = idx_inc(rd_q);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (clk_en) begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

endmodule
`default_nettype wire

// ### hw/aso_pkg.sv
`default_nettype none
package aso_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned HZ_PER_MHZ    = 1_000_000;
  // power-on reset phase, in microseconds
  localparam int unsigned POR_TIME_US   = 500;
  localparam int unsigned POR_CYC       = POR_TIME_US * (CLK_HZ / HZ_PER_MHZ);
  // switched-capacitor sampling clock, 6.5 us period
  localparam int unsigned SAMP_HZ       = 153_600;
  localparam int unsigned SAMP_HALF_CYC = CLK_HZ / (2 * SAMP_HZ);
  // serial clock half period, taken from the same oscillator
  localparam int unsigned SCK_HALF_CYC  = SAMP_HALF_CYC;

  // ==========================================================
  // result frame
  localparam int unsigned FRAME_BITS    = 32;
  localparam int unsigned RES_W         = FRAME_BITS - 1;
  localparam logic [5:0]  FRAME_LAST    = 6'h20;
  localparam logic [5:0]  BIT_FIRST     = 6'h01;
  localparam logic        EOC_DONE      = 1'h0;
  localparam int unsigned FIFO_DEPTH    = 8;

  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_POR,
    ST_EXT,
    ST_CONV,
    ST_SLEEP,
    ST_OUT_HI,
    ST_OUT_LO
  } aso_state_t;

endpackage
`default_nettype wire

// ### hw/aso_top.sv
// What this block does
// - power-on reset ends about 0.5 ms after supply good; clock mode chosen then
// - weak pull-up on clock pin during reset; pin low at end selects external mode
// - while converting, serial clock and data are both driven high
// - conversion done: data goes low, clock driven low outside autostart, device sleeps
// - continuous mode sleeps at least half a clock period, then outputs
// - output runs from first to 32nd rising clock edge, clock driven out
// - data changes on every falling clock edge during output
// - after the 32nd edge data goes high, clock stays high while converting
// - autostart: chip select held high by weak pull-up while converting
// - autostart: sleep discharges chip-select capacitor with small current
// - autostart: output starts when chip select falls below threshold
// - autostart: after 32nd edge chip select pulled high, new conversion
// - autostart: mode re-chosen at threshold crossing, clock pull-up on
// - sampling network clocked at 153,600 Hz, 6.5 us period
// - clock pin pull-up is off whenever that pin reads low through the synchroniser, outside reset
`timescale 1ns/100ps
`default_nettype none
module aso_top
  import aso_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_CYC,
  parameter int unsigned SCK_HALF   = SCK_HALF_CYC,
  parameter int unsigned SAMP_HALF  = SAMP_HALF_CYC,
  parameter int unsigned DEPTH      = FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             supply_ok,
  input  wire logic             cfg_autostart,
  input  wire logic             sck_i,
  output logic                  sck_o,
  output logic                  sck_oe_n,
  output logic                  sck_pu_en,
  output logic                  sdo_o,
  output logic                  sdo_oe_n,
  input  wire logic             cs_below_thr,
  output logic                  cs_pu_en,
  output logic                  cs_dis_en,
  output logic                  conv_start,
  input  wire logic             res_valid,
  output logic                  res_ready,
  input  wire logic [RES_W-1:0] res_data,
  output logic                  samp_clk,
  output logic                  mode_ext
);

  // ==========================================================
  // pin synchronisers
  // stage one is read only by stage two
  // clock pin idles high under its pull-up; a low reset value would drop the pull-up
  localparam logic [2:0] SYNC_IDLE = 3'h2;
  logic [2:0] meta_q, sync_q;
  logic       supply_s, sck_s, below_s;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= SYNC_IDLE;
      sync_q <= SYNC_IDLE;
    end else if (clk_en) begin
      meta_q <= {supply_ok, sck_i, cs_below_thr};
      sync_q <= meta_q;
    end
  end

  assign supply_s = sync_q[2];
  assign sck_s    = sync_q[1];
  assign below_s  = sync_q[0];

  // ==========================================================
  // result buffer
  logic             fifo_valid;
  logic             fifo_pop;
  logic [RES_W-1:0] fifo_data;

  aso_fifo #(
    .W     (RES_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .in_data   (res_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ==========================================================
  // sampling clock
  logic [31:0] samp_cnt_q, samp_cnt_d;
  logic        samp_clk_q, samp_clk_d;

  always_comb begin
    samp_cnt_d = samp_cnt_q + 32'h1;
    samp_clk_d = samp_clk_q;
    if (samp_cnt_q == 32'(SAMP_HALF - 1)) begin
      samp_cnt_d = '0;
      samp_clk_d = !samp_clk_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      samp_cnt_q <= '0;
      samp_clk_q <= 1'h0;
    end else if (clk_en) begin
      samp_cnt_q <= samp_cnt_d;
      samp_clk_q <= samp_clk_d;
    end
  end

  assign samp_clk = samp_clk_q;

  // ==========================================================
  // output sequencer
  aso_state_t       st_q, st_d;
  logic [31:0]      por_cnt_q, por_cnt_d;
  logic [31:0]      sck_cnt_q, sck_cnt_d;
  logic [5:0]       bit_q, bit_d;
  logic [FRAME_BITS-1:0] shift_q, shift_d;
  logic             start_q, start_d;
  logic             sck_q, sck_d, sck_oe_n_q, sck_oe_n_d, sck_pu_q, sck_pu_d;
  logic             sdo_q, sdo_d, sdo_oe_n_q, sdo_oe_n_d;
  logic             cs_pu_q, cs_pu_d, cs_dis_q, cs_dis_d;
  logic             half_done;

  assign half_done = (sck_cnt_q == 32'(SCK_HALF - 1));
  assign fifo_pop  = (st_q == ST_CONV);

  always_comb begin
    st_d      = st_q;
    por_cnt_d = por_cnt_q;
    sck_cnt_d = sck_cnt_q;
    bit_d     = bit_q;
    shift_d   = shift_q;
    start_d   = 1'h0;
    unique case (st_q)
      ST_POR: begin
        // supply dip restarts the timer
        por_cnt_d = supply_s ? por_cnt_q + 32'h1 : '0;
        if (supply_s && por_cnt_q == 32'(POR_CYCLES - 1)) begin
          if (sck_s) begin
            st_d    = ST_CONV;
            start_d = 1'h1;
          end else begin
            st_d = ST_EXT;
          end
        end
      end
      ST_EXT: begin
        st_d = ST_EXT;
      end
      ST_CONV: begin
        // a buffered word ends the conversion
        if (fifo_valid) begin
          st_d      = ST_SLEEP;
          shift_d   = {EOC_DONE, fifo_data};
          sck_cnt_d = '0;
        end
      end
      ST_SLEEP: begin
        if (cfg_autostart) begin
          if (below_s) begin
            sck_cnt_d = '0;
            // released clock sits high: a driven low phase makes the status rise
            bit_d     = BIT_FIRST - 6'h01;
            // a pin held low at the crossing hands over to external mode
            st_d      = sck_s ? ST_OUT_LO : ST_EXT;
          end
        end else begin
          sck_cnt_d = sck_cnt_q + 32'h1;
          if (half_done) begin
            st_d      = ST_OUT_HI;
            sck_cnt_d = '0;
            bit_d     = BIT_FIRST;
          end
        end
      end
      ST_OUT_HI: begin
        sck_cnt_d = sck_cnt_q + 32'h1;
        if (half_done) begin
          sck_cnt_d = '0;
          if (bit_q == FRAME_LAST) begin
            st_d    = ST_CONV;
            start_d = 1'h1;
          end else begin
            st_d    = ST_OUT_LO;
            shift_d = {shift_q[FRAME_BITS-2:0], 1'h0};
          end
        end
      end
      ST_OUT_LO: begin
        sck_cnt_d = sck_cnt_q + 32'h1;
        if (half_done) begin
          sck_cnt_d = '0;
          st_d      = ST_OUT_HI;
          bit_d     = bit_q + 6'h01;
        end
      end
    endcase
  end

  // pin drive follows the next state so pins and state move together
  always_comb begin
    sck_d      = 1'h1;
    sck_oe_n_d = 1'h0;
    sdo_d      = 1'h1;
    sdo_oe_n_d = 1'h0;
    cs_pu_d    = 1'h0;
    cs_dis_d   = 1'h0;
    unique case (st_d)
      ST_POR, ST_EXT: begin
        sck_oe_n_d = 1'h1;
        sdo_oe_n_d = 1'h1;
      end
      ST_CONV: begin
        cs_pu_d = cfg_autostart;
      end
      ST_SLEEP: begin
        sck_d = 1'h0;
        sdo_d = shift_d[FRAME_BITS-1];
        // in autostart the clock is released so the pull-up can show a driven-low pin
        sck_oe_n_d = cfg_autostart;
        cs_dis_d   = cfg_autostart;
      end
      ST_OUT_HI: begin
        sdo_d = shift_d[FRAME_BITS-1];
      end
      ST_OUT_LO: begin
        sck_d = 1'h0;
        sdo_d = shift_d[FRAME_BITS-1];
      end
    endcase
    // pull-up only on a released pin that reads high
    sck_pu_d = sck_oe_n_d && sck_s;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q       <= ST_POR;
      por_cnt_q  <= '0;
      sck_cnt_q  <= '0;
      bit_q      <= '0;
      shift_q    <= '0;
      start_q    <= 1'h0;
      sck_q      <= 1'h1;
      sck_oe_n_q <= 1'h1;
      sck_pu_q   <= 1'h1;
      sdo_q      <= 1'h1;
      sdo_oe_n_q <= 1'h1;
      cs_pu_q    <= 1'h0;
      cs_dis_q   <= 1'h0;
    end else if (clk_en) begin
      st_q       <= st_d;
      por_cnt_q  <= por_cnt_d;
      sck_cnt_q  <= sck_cnt_d;
      bit_q      <= bit_d;
      shift_q    <= shift_d;
      start_q    <= start_d;
      sck_q      <= sck_d;
      sck_oe_n_q <= sck_oe_n_d;
      sck_pu_q   <= sck_pu_d;
      sdo_q      <= sdo_d;
      sdo_oe_n_q <= sdo_oe_n_d;
      cs_pu_q    <= cs_pu_d;
      cs_dis_q   <= cs_dis_d;
    end
  end

  assign sck_o      = sck_q;
  assign sck_oe_n   = sck_oe_n_q;
  assign sck_pu_en  = sck_pu_q;
  assign sdo_o      = sdo_q;
  assign sdo_oe_n   = sdo_oe_n_q;
  assign cs_pu_en   = cs_pu_q;
  assign cs_dis_en  = cs_dis_q;
  assign conv_start = start_q;
  assign mode_ext   = (st_q == ST_EXT);

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !clk_en);

  property p_por_end;
    st_q == ST_POR && $past(st_q) == ST_POR && $past(por_cnt_q) < 32'(POR_CYCLES - 1)
      |-> por_cnt_q <= 32'(POR_CYCLES - 1);
  endproperty
  a_por_end: assert property (p_por_end) else $error("reset timer overran");

  property p_por_leave;
    st_q == ST_POR && st_d != ST_POR |-> por_cnt_q == 32'(POR_CYCLES - 1);
  endproperty
  a_por_leave: assert property (p_por_leave) else $error("reset left early");

  property p_mode_pick;
    st_q == ST_POR && st_d != ST_POR |=> (st_q == ST_EXT) == !$past(sck_s);
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("wrong clock mode");

  property p_conv_high;
    st_q == ST_CONV |-> sck_o && sdo_o && !sck_oe_n && !sdo_oe_n;
  endproperty
  a_conv_high: assert property (p_conv_high) else $error("lines low in conversion");

  property p_done_low;
    st_q == ST_CONV && fifo_valid |=> st_q == ST_SLEEP && !sck_o && !sdo_o;
  endproperty
  a_done_low: assert property (p_done_low) else $error("no sleep on completion");

  property p_sleep_len;
    st_q == ST_SLEEP && !cfg_autostart && st_d == ST_OUT_HI
      |-> sck_cnt_q == 32'(SCK_HALF - 1);
  endproperty
  a_sleep_len: assert property (p_sleep_len) else $error("sleep too short");

  property p_frame_end;
    st_q == ST_OUT_HI && half_done && bit_q == FRAME_LAST
      |=> st_q == ST_CONV && sck_o && sdo_o && conv_start;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame did not end at 32");

  property p_sdo_fall;
    (st_q == ST_OUT_HI || st_q == ST_OUT_LO) && $changed(sdo_o)
      |-> st_q == ST_OUT_LO && $past(st_q) == ST_OUT_HI;
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("data moved off falling edge");

  property p_cs_pull;
    st_q == ST_CONV |-> cs_pu_en == cfg_autostart && !cs_dis_en;
  endproperty
  a_cs_pull: assert property (p_cs_pull) else $error("chip select pull wrong");

  property p_discharge;
    st_q == ST_SLEEP && cfg_autostart |-> cs_dis_en && !cs_pu_en && sck_oe_n;
  endproperty
  a_discharge: assert property (p_discharge) else $error("no discharge in sleep");

  property p_thresh;
    st_q == ST_SLEEP && cfg_autostart && below_s |=> st_q == ST_OUT_LO || st_q == ST_EXT;
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold ignored");

  property p_samp_period;
    $changed(samp_clk) |-> $past(samp_cnt_q) == 32'(SAMP_HALF - 1);
  endproperty
  a_samp_period: assert property (p_samp_period) else $error("sampling clock off rate");

  property p_pu_off;
    !$past(sck_s) |-> !sck_pu_en;
  endproperty
  a_pu_off: assert property (p_pu_off) else $error("pull-up on a low pin");

endmodule
`default_nettype wire
